//--- rtl/sleep_wdt_pkg.sv
// Purpose: shared constants for the sleep power and watchdog block
// Assumes: 32-bit classic wishbone, word-aligned registers
// Notes: time-out select follows the prescale table of the period field
package sleep_wdt_pkg;
  // register byte offsets
  localparam logic [7:0] regulator_sleep_control_off = 8'h00;
  localparam logic [7:0] watchdog_control_off = 8'h04;
  localparam logic [7:0] power_status_off = 8'h08;
  localparam logic [7:0] irq_status_off = 8'h0c;
  localparam logic [7:0] irq_mask_off = 8'h10;
  // regulator_sleep_control fields
  localparam int lowpower_sleep_select_bit = 1;
  localparam int reg_reserved_bit = 0;
  localparam logic [7:0] regulator_sleep_control_rst = 8'h01;
  // watchdog control fields
  localparam int soft_watchdog_enable_bit = 0;
  localparam int period_sel_lsb = 1;
  localparam int period_sel_msb = 5;
  localparam logic [4:0] period_sel_rst = 5'h0b;
  localparam logic [4:0] period_sel_max = 5'h12;
  // power status fields
  localparam int timeout_status_bit = 0;
  localparam int powerdown_status_bit = 1;
  localparam int sleeping_bit = 2;
  localparam int regulator_lowpower_bit = 3;
  // interrupt bits
  localparam int irq_wdt_wake_bit = 0;
  localparam int irq_sleep_exit_bit = 1;
  localparam int irq_width = 2;
  // watchdog mode encodings
  localparam logic [1:0] wdt_mode_off = 2'h0;
  localparam logic [1:0] wdt_mode_soft = 2'h1;
  localparam logic [1:0] wdt_mode_awake = 2'h2;
  localparam logic [1:0] wdt_mode_on = 2'h3;
  // timing: 31 kHz oscillator, 32 ticks per nominal 1 ms base interval
  localparam int min_prescale_log2 = 5;
  localparam int wdt_count_width = 24;
  localparam int clk_freq_hz = 10_000_000;
  localparam int stab_delay_us = 20;
  localparam int stab_delay_cycles = (stab_delay_us * (clk_freq_hz / 1_000_000) > 0) ?
    stab_delay_us * (clk_freq_hz / 1_000_000) : 1;
  localparam int stab_count_width = 16;
endpackage

//--- rtl/wdt_ctl_if.sv
// Purpose: control and status link between the top and the watchdog counter
// Assumes: single clock domain
// Notes: the tick is a one-cycle pulse per rising oscillator edge
`timescale 1ns/1ps
interface wdt_ctl_if;
  logic run;
  logic clear;
  logic tick;
  logic [4:0] period_sel;
  logic expired;
  modport ctl (output run, output clear, output tick, output period_sel, input expired);
  modport cnt (input run, input clear, input tick, input period_sel, output expired);
endinterface

//--- rtl/wdt_counter.sv
// Purpose: watchdog count of oscillator ticks against the selected period
// Assumes: tick is one clk cycle wide, at most every other cycle
// Notes: expired pulses for one cycle, on the same tick that restarts the count
`timescale 1ns/1ps
module wdt_counter
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  wdt_ctl_if.cnt ctl
);
  logic [sleep_wdt_pkg::wdt_count_width-1:0] count_reg;
  logic [sleep_wdt_pkg::wdt_count_width-1:0] limit;
  logic expired_reg;

  // reserved codes above the table fall back to the shortest interval
  function automatic logic [sleep_wdt_pkg::wdt_count_width-1:0] period_limit(
    input logic [4:0] sel);
    logic [4:0] eff;
    eff = (sel > sleep_wdt_pkg::period_sel_max) ? 5'h00 : sel;
    period_limit = (sleep_wdt_pkg::wdt_count_width)'(1) <<
      (eff + 5'(sleep_wdt_pkg::min_prescale_log2));
    period_limit = period_limit - 1'b1;
  endfunction

  assign limit = period_limit(ctl.period_sel);
  assign ctl.expired = expired_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || ctl.clear || !ctl.run)
    begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end
    else if (ctl.tick)
    begin
      if (count_reg >= limit)
      begin
        count_reg <= '0;
        expired_reg <= 1'b1;
      end
      else
      begin
        count_reg <= count_reg + 1'b1;
        expired_reg <= 1'b0;
      end
    end
    else
    begin
      expired_reg <= 1'b0;
    end
  end
endmodule

//--- rtl/sleep_power_watchdog.sv
// Purpose: sleep-time regulator control and watchdog with wishbone registers
// Assumes: sleep request and wake event come from the core as pulses
// Notes: watchdog counts the slow oscillator, sampled on clk_i
`timescale 1ns/1ps
module sleep_power_watchdog
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // core and configuration
  input wire logic [1:0] watchdog_mode_cfg_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic sleep_enter_i,
  input wire logic wake_event_i,
  input wire logic incompat_periph_en_i,
  input wire logic low_freq_internal_osc_i,
  // power and reset outputs
  output logic regulator_lowpower_o,
  output logic sleeping_o,
  output logic core_run_o,
  output logic wdt_reset_o,
  output logic irq_o
);
  typedef enum logic [1:0] {pw_awake, pw_sleep, pw_stabilize} pw_state_t;

  wdt_ctl_if wdt_bus ();

  pw_state_t state_reg;
  logic lowpower_sleep_select_reg;
  logic lowpower_latched_reg;
  logic soft_watchdog_enable_reg;
  logic [4:0] period_sel_reg;
  logic timeout_status_reg;
  logic powerdown_status_reg;
  logic [sleep_wdt_pkg::irq_width-1:0] irq_status_reg;
  logic [sleep_wdt_pkg::irq_width-1:0] irq_mask_reg;
  logic [sleep_wdt_pkg::stab_count_width-1:0] stab_cnt_reg;
  logic osc_q_reg;
  logic tick_reg;
  logic wb_req;
  logic wr_stb;
  logic wr_lo;
  logic wdt_run;
  logic in_sleep;
  logic wake_now;
  logic [sleep_wdt_pkg::irq_width-1:0] irq_set;
  logic [31:0] rd_data;

  // word decode shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wr_stb = wb_req && we_i;
  assign wr_lo = wr_stb && sel_i[0];
  assign in_sleep = (state_reg == pw_sleep);

  // mode decode of the watchdog
  always_comb
  begin
    unique case (watchdog_mode_cfg_i)
      sleep_wdt_pkg::wdt_mode_on: wdt_run = 1'b1;
      sleep_wdt_pkg::wdt_mode_awake: wdt_run = !in_sleep;
      sleep_wdt_pkg::wdt_mode_soft: wdt_run = soft_watchdog_enable_reg;
      sleep_wdt_pkg::wdt_mode_off: wdt_run = 1'b0;
    endcase
  end

  assign wdt_bus.run = wdt_run && (state_reg != pw_stabilize);
  // cleared on the clear instruction and on every sleep entry or exit
  assign wdt_bus.clear = watchdog_clear_instr_i ||
    (sleep_enter_i && state_reg == pw_awake) || wake_now;
  assign wdt_bus.tick = tick_reg;
  assign wdt_bus.period_sel = period_sel_reg;
  assign wake_now = in_sleep && (wake_event_i || wdt_bus.expired);

  wdt_counter u_counter
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctl(wdt_bus)
  );

  // rising edge of the slow oscillator; no system clock time base
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_q_reg <= 1'b0;
      tick_reg <= 1'b0;
    end
    else
    begin
      osc_q_reg <= low_freq_internal_osc_i;
      tick_reg <= low_freq_internal_osc_i && !osc_q_reg;
    end
  end

  // power state sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= pw_awake;
      lowpower_latched_reg <= 1'b0;
      stab_cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        pw_awake:
          if (sleep_enter_i)
          begin
            state_reg <= pw_sleep;
            lowpower_latched_reg <= lowpower_sleep_select_reg;
          end
        pw_sleep:
          if (wake_now)
          begin
            if (lowpower_latched_reg && !incompat_periph_en_i)
            begin
              state_reg <= pw_stabilize;
              stab_cnt_reg <= (sleep_wdt_pkg::stab_count_width)'(
                sleep_wdt_pkg::stab_delay_cycles - 1);
            end
            else
            begin
              state_reg <= pw_awake;
            end
          end
        pw_stabilize:
          if (stab_cnt_reg == '0)
          begin
            state_reg <= pw_awake;
          end
          else
          begin
            stab_cnt_reg <= stab_cnt_reg - 1'b1;
          end
      endcase
    end
  end

  // regulator, sleep and run outputs from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      regulator_lowpower_o <= 1'b0;
      sleeping_o <= 1'b0;
      core_run_o <= 1'b1;
    end
    else
    begin
      // peripheral override checked live, it may be enabled mid-sleep
      regulator_lowpower_o <= in_sleep && !wake_now && lowpower_latched_reg &&
        !incompat_periph_en_i;
      sleeping_o <= in_sleep && !wake_now;
      core_run_o <= (state_reg == pw_awake && !sleep_enter_i) ||
        (state_reg == pw_stabilize && stab_cnt_reg == '0);
    end
  end

  // time-out while awake resets; while asleep it only wakes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wdt_reset_o <= 1'b0;
    end
    else
    begin
      wdt_reset_o <= wdt_bus.expired && !in_sleep;
    end
  end

  // status bits, active low as on the core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timeout_status_reg <= 1'b1;
      powerdown_status_reg <= 1'b1;
    end
    else if (in_sleep && wdt_bus.expired)
    begin
      timeout_status_reg <= 1'b0;
      powerdown_status_reg <= 1'b0;
    end
    else if (state_reg == pw_awake && sleep_enter_i)
    begin
      timeout_status_reg <= 1'b1;
      powerdown_status_reg <= 1'b0;
    end
    else if (watchdog_clear_instr_i)
    begin
      timeout_status_reg <= 1'b1;
      powerdown_status_reg <= 1'b1;
    end
  end

  // control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lowpower_sleep_select_reg <= 1'b0;
      soft_watchdog_enable_reg <= 1'b0;
      period_sel_reg <= sleep_wdt_pkg::period_sel_rst;
      irq_mask_reg <= '0;
    end
    else if (wr_lo)
    begin
      if (hit(adr_i, sleep_wdt_pkg::regulator_sleep_control_off))
      begin
        lowpower_sleep_select_reg <= dat_i[sleep_wdt_pkg::lowpower_sleep_select_bit];
      end
      if (hit(adr_i, sleep_wdt_pkg::watchdog_control_off))
      begin
        soft_watchdog_enable_reg <= dat_i[sleep_wdt_pkg::soft_watchdog_enable_bit];
        period_sel_reg <= dat_i[sleep_wdt_pkg::period_sel_msb:sleep_wdt_pkg::period_sel_lsb];
      end
      if (hit(adr_i, sleep_wdt_pkg::irq_mask_off))
      begin
        irq_mask_reg <= dat_i[sleep_wdt_pkg::irq_width-1:0];
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  assign irq_set[sleep_wdt_pkg::irq_wdt_wake_bit] = in_sleep && wdt_bus.expired;
  assign irq_set[sleep_wdt_pkg::irq_sleep_exit_bit] = wake_now;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_reg <= '0;
    end
    else if (wr_lo && hit(adr_i, sleep_wdt_pkg::irq_status_off))
    begin
      irq_status_reg <= (irq_status_reg & ~dat_i[sleep_wdt_pkg::irq_width-1:0]) | irq_set;
    end
    else
    begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // read mux; unmapped words read zero
  always_comb
  begin
    rd_data = '0;
    if (hit(adr_i, sleep_wdt_pkg::regulator_sleep_control_off))
    begin
      rd_data[sleep_wdt_pkg::reg_reserved_bit] = 1'b1;
      rd_data[sleep_wdt_pkg::lowpower_sleep_select_bit] = lowpower_sleep_select_reg;
    end
    else if (hit(adr_i, sleep_wdt_pkg::watchdog_control_off))
    begin
      rd_data[sleep_wdt_pkg::soft_watchdog_enable_bit] = soft_watchdog_enable_reg;
      rd_data[sleep_wdt_pkg::period_sel_msb:sleep_wdt_pkg::period_sel_lsb] = period_sel_reg;
    end
    else if (hit(adr_i, sleep_wdt_pkg::power_status_off))
    begin
      rd_data[sleep_wdt_pkg::timeout_status_bit] = timeout_status_reg;
      rd_data[sleep_wdt_pkg::powerdown_status_bit] = powerdown_status_reg;
      rd_data[sleep_wdt_pkg::sleeping_bit] = in_sleep;
      rd_data[sleep_wdt_pkg::regulator_lowpower_bit] = regulator_lowpower_o;
    end
    else if (hit(adr_i, sleep_wdt_pkg::irq_status_off))
    begin
      rd_data[sleep_wdt_pkg::irq_width-1:0] = irq_status_reg;
    end
    else if (hit(adr_i, sleep_wdt_pkg::irq_mask_off))
    begin
      rd_data[sleep_wdt_pkg::irq_width-1:0] = irq_mask_reg;
    end
  end

  // one-cycle ack; read data registered with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= wb_req;
      dat_o <= (wb_req && !we_i) ? rd_data : '0;
    end
  end
endmodule

//--- testbench/sleep_power_watchdog_properties.sv
// Purpose: port-level properties of the sleep power and watchdog block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module sleep_power_watchdog_checker
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // core and power
  input wire logic [1:0] watchdog_mode_cfg_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic sleep_enter_i,
  input wire logic incompat_periph_en_i,
  input wire logic regulator_lowpower_o,
  input wire logic sleeping_o,
  input wire logic core_run_o,
  input wire logic wdt_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_bus_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_lowpower_only_asleep: assert property (regulator_lowpower_o |-> sleeping_o || !core_run_o)
    else $error("regulator low-power while running");
  a_incompat_forces_normal: assert property (
    $past(incompat_periph_en_i) |-> !regulator_lowpower_o)
    else $error("regulator low-power with incompatible peripheral");
  // only a fall at wake counts; a peripheral enabled mid-sleep also drops it
  a_stab_after_lowpower: assert property (
    $fell(regulator_lowpower_o) && !sleeping_o |-> !core_run_o[*8])
    else $error("core resumed without stabilization");
  a_sleep_stops_core: assert property (sleeping_o |-> !core_run_o)
    else $error("core running in sleep");
  a_sleep_entry: assert property (
    sleep_enter_i && !sleeping_o && core_run_o |-> ##[1:2] sleeping_o)
    else $error("sleep request not taken");
  a_no_reset_asleep: assert property (wdt_reset_o |-> !sleeping_o)
    else $error("watchdog reset during sleep");
  a_reset_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("watchdog reset longer than one cycle");
  a_mode_off_quiet: assert property (
    (watchdog_mode_cfg_i == sleep_wdt_pkg::wdt_mode_off)[*6] |-> !wdt_reset_o)
    else $error("watchdog reset while mode off");
  a_clear_restarts: assert property (watchdog_clear_instr_i |-> ##3 !wdt_reset_o[*8])
    else $error("watchdog reset right after clear");
  c_lowpower_sleep: cover property (sleeping_o && regulator_lowpower_o);
  c_wdt_reset: cover property (wdt_reset_o);
  c_stab_wake: cover property ($fell(sleeping_o) && !core_run_o);
endmodule

bind sleep_power_watchdog sleep_power_watchdog_checker u_chk (.clk_i, .rst_i, .cyc_i,
  .stb_i, .dat_o, .ack_o, .watchdog_mode_cfg_i, .watchdog_clear_instr_i, .sleep_enter_i,
  .incompat_periph_en_i, .regulator_lowpower_o, .sleeping_o, .core_run_o, .wdt_reset_o);

//--- testbench/sleep_power_watchdog_tb.sv
// Purpose: self-checking bench for the sleep power and watchdog block
// Assumes: osc input rises every 4 clk cycles, period select 0 (32 ticks)
// Notes: watchdog reset pulses are counted, not fed back
`timescale 1ns/1ps
module sleep_power_watchdog_tb;
  localparam logic [7:0] off_reg = sleep_wdt_pkg::regulator_sleep_control_off;
  localparam logic [7:0] off_wdc = sleep_wdt_pkg::watchdog_control_off;
  localparam logic [7:0] off_pwr = sleep_wdt_pkg::power_status_off;
  localparam logic [7:0] off_irs = sleep_wdt_pkg::irq_status_off;
  localparam logic [7:0] off_irm = sleep_wdt_pkg::irq_mask_off;
  localparam int stab = sleep_wdt_pkg::stab_delay_cycles;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [1:0] watchdog_mode_cfg_i = 2'h0, osc_div = 2'h0;
  logic watchdog_clear_instr_i = 1'b0, sleep_enter_i = 1'b0, wake_event_i = 1'b0;
  logic incompat_periph_en_i = 1'b0, low_freq_internal_osc_i = 1'b0, osc_run = 1'b1;
  logic ack_o, regulator_lowpower_o, sleeping_o, core_run_o, wdt_reset_o, irq_o;
  logic [1:0] md [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  logic en [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic ex [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int failures = 0, tests_run = 0, cycles = 0, rst_seen = 0, base, n;

  sleep_power_watchdog DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .watchdog_mode_cfg_i, .watchdog_clear_instr_i, .sleep_enter_i,
    .wake_event_i, .incompat_periph_en_i, .low_freq_internal_osc_i, .regulator_lowpower_o,
    .sleeping_o, .core_run_o, .wdt_reset_o, .irq_o);

  always #50 clk_i = ~clk_i;

  task print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // slow oscillator stand-in, reset pulse count and hang guard
  always @(posedge clk_i)
  begin
    if (osc_run)
      osc_div <= osc_div + 2'h1;
    low_freq_internal_osc_i <= osc_div[1];
    if (wdt_reset_o === 1'b1)
      rst_seen <= rst_seen + 1;
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      failures++;
      print_verdict();
    end
  end

  task step(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // classic single cycle; called just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    // no local limit: the cycle ceiling ends a hung wait
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task sleep_now();
    sleep_enter_i <= 1'b1;
    @(posedge clk_i);
    sleep_enter_i <= 1'b0;
    step(3);
  endtask

  task wake();
    wake_event_i <= 1'b1;
    @(posedge clk_i);
    wake_event_i <= 1'b0;
    n = 0;
    while (core_run_o !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task clear();
    watchdog_clear_instr_i <= 1'b1;
    @(posedge clk_i);
    watchdog_clear_instr_i <= 1'b0;
  endtask

  initial
  begin
    step(3);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, off_reg, 0);
    chk("sleep ctl", 32'h1, q);
    wb(0, off_wdc, 0);
    chk("wdt ctl", {26'h0, sleep_wdt_pkg::period_sel_rst, 1'b0}, q);
    wb(0, off_pwr, 0);
    chk("power status", 32'h3, q);
    wb(0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1, off_reg, 32'h1);
    wb(0, off_reg, 0);
    chk("reserved bit", 32'h1, q);
    $display("test registers done");
    wb(1, off_reg, 32'h3);
    sleep_now();
    chk("lowpower", 1, regulator_lowpower_o);
    step(20);
    chk("lowpower hold", 1, regulator_lowpower_o);
    wake();
    chk("stab delay", 1, n >= stab && n <= stab + 4);
    chk("lowpower off", 0, regulator_lowpower_o);
    wb(1, off_reg, 32'h1);
    sleep_now();
    chk("normal sleep", 0, regulator_lowpower_o);
    wb(1, off_reg, 32'h3);
    step(5);
    chk("select latched", 0, regulator_lowpower_o);
    wake();
    chk("fast wake", 1, n <= 4);
    sleep_now();
    chk("next sleep", 1, regulator_lowpower_o);
    wake();
    incompat_periph_en_i <= 1'b1;
    sleep_now();
    chk("incompat", 0, regulator_lowpower_o);
    wake();
    incompat_periph_en_i <= 1'b0;
    $display("test sleep modes done");
    for (int i = 0; i < 5; i++)
    begin
      wb(1, off_wdc, {31'h0, en[i]});
      watchdog_mode_cfg_i <= md[i];
      clear();
      base = rst_seen;
      step(300);
      chk("wdt mode", ex[i], rst_seen != base);
    end
    watchdog_mode_cfg_i <= 2'h3;
    clear();
    base = rst_seen;
    repeat (6)
    begin
      step(60);
      clear();
    end
    chk("cleared in time", 0, rst_seen != base);
    osc_run <= 1'b0;
    clear();
    base = rst_seen;
    step(300);
    chk("osc stopped", 0, rst_seen != base);
    osc_run <= 1'b1;
    $display("test watchdog modes done");
    watchdog_mode_cfg_i <= 2'h2;
    wb(1, off_reg, 32'h1);
    wb(1, off_irs, 32'h3);
    sleep_now();
    base = rst_seen;
    step(300);
    chk("awake-only sleep", 1, sleeping_o);
    watchdog_mode_cfg_i <= 2'h3;
    n = 0;
    while (sleeping_o !== 1'b0 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    watchdog_mode_cfg_i <= 2'h0;
    chk("wdt wake", 1, n < 400);
    chk("no reset", 0, rst_seen != base);
    wb(0, off_pwr, 0);
    chk("to pd", 2'h0, q[1:0]);
    wb(0, off_irs, 0);
    chk("irq status", 2'h3, q[1:0]);
    chk("irq masked", 0, irq_o);
    wb(1, off_irm, 32'h1);
    step(2);
    chk("irq raised", 1, irq_o);
    wb(1, off_irs, 32'h3);
    step(2);
    chk("irq cleared", 0, irq_o);
    clear();
    step(2);
    wb(0, off_pwr, 0);
    chk("status set", 2'h3, q[1:0]);
    $display("test sleep timeout done");
    print_verdict();
  end
endmodule
